// [pkg/dtvi_map.vh]
`ifndef DTVI_MAP_VH
`define DTVI_MAP_VH
// Register addresses on the core side
`define DTVI_A_MODE 8'hf1
`define DTVI_A_CNT1 8'hf2
`define DTVI_A_SCL1 8'hf3
`define DTVI_A_CNT0 8'hf4
`define DTVI_A_SCL0 8'hf5
`define DTVI_A_PRIO 8'hf9
`define DTVI_A_IRQ 8'hfa
`define DTVI_A_MASK 8'hfb
// Reset values
`define DTVI_RST_MODE 8'h00
`define DTVI_RST_PRE 8'h00
`define DTVI_RST_CNT 8'h00
`define DTVI_RST_PRIO 8'h00
`define DTVI_RST_IRQ 6'h00
`define DTVI_RST_MASK 8'h00
`define DTVI_RST_SRC 3'h0
`define DTVI_RST_VEC 16'h0000
`define DTVI_RST_DIV4 2'h0
`define DTVI_RST_LINES 3'h7
`define DTVI_ZERO8 8'h00
// Timer mode register fields
`define DTVI_MODE_LD0 0
`define DTVI_MODE_EN0 1
`define DTVI_MODE_LD1 2
`define DTVI_MODE_EN1 3
`define DTVI_MODE_EXT 5:4
`define DTVI_MODE_KEEP 8'hfa
// External timer input modes
`define DTVI_EXT_CLK 2'h0
`define DTVI_EXT_GATE 2'h1
`define DTVI_EXT_TRIG 2'h2
`define DTVI_EXT_RTRIG 2'h3
// Prescaler register fields
`define DTVI_PRE_CONT 0
`define DTVI_PRE_SRC 1
`define DTVI_PRE_DIV 7:2
// Mask and priority fields
`define DTVI_MASK_GEN 7
`define DTVI_MASK_SRC 5:0
`define DTVI_MASK_NOGEN 8'h7f
`define DTVI_PRIO_TOP 2:0
`define DTVI_IRQ_BITS 5:0
// Interrupt source numbers
`define DTVI_SRC_L2F 0
`define DTVI_SRC_L3F 1
`define DTVI_SRC_L1F 2
`define DTVI_SRC_L2R 3
`define DTVI_SRC_CNT0 4
`define DTVI_SRC_CNT1 5
// Internal timer clock is the system clock divided by four
`define DTVI_DIV4_LAST 2'h3
`define DTVI_DIV4_STEP 2'h1
`endif

// [core/dtvi_timer.v]
`timescale 1ns/1ps
`default_nettype none
// One prescaler plus its down-counter
module dtvi_timer #(
    parameter PRE_W = 6,
    parameter CNT_W = 8
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire tick_i,
    input wire run_i,
    input wire load_i,
    input wire cont_i,
    input wire [PRE_W-1:0] pre_init_i,
    input wire [CNT_W-1:0] cnt_init_i,
    output wire [CNT_W-1:0] count_o,
    output wire eoc_o,
    output wire done_o
);
    localparam [PRE_W-1:0] P_ONE = {{(PRE_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] C_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] C_ZERO = {CNT_W{1'b0}};
    reg [PRE_W-1:0] pre_ff; // Prescaler, zero means full range
    reg [CNT_W-1:0] cnt_ff; // Counter, zero means full range
    reg eoc_ff; // End of count pulse
    reg done_ff; // Halted until next load
    // Halted at reset so enabling without a load does nothing
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pre_ff <= {PRE_W{1'b0}};
            cnt_ff <= C_ZERO;
            eoc_ff <= 1'b0;
            done_ff <= 1'b1;
        end
        else
        begin
            eoc_ff <= 1'b0;
            if (load_i)
            begin
                // Restart from initial values
                pre_ff <= pre_init_i;
                cnt_ff <= cnt_init_i;
                done_ff <= 1'b0;
            end
            else if (run_i && !done_ff && tick_i)
            begin
                if (pre_ff == P_ONE)
                begin
                    // Prescaler end: reload it, step counter
                    pre_ff <= pre_init_i;
                    if (cnt_ff == C_ONE)
                    begin
                        eoc_ff <= 1'b1;
                        // Reload or stop at zero
                        if (cont_i)
                            cnt_ff <= cnt_init_i;
                        else
                        begin
                            cnt_ff <= C_ZERO;
                            done_ff <= 1'b1;
                        end
                    end
                    else
                        cnt_ff <= cnt_ff - C_ONE;
                end
                else
                    pre_ff <= pre_ff - P_ONE;
            end
        end
    end
    assign count_o = cnt_ff;
    assign eoc_o = eoc_ff;
    assign done_o = done_ff;
endmodule // dtvi_timer
`default_nettype wire

// [core/dtvi_prio.v]
`timescale 1ns/1ps
`default_nettype none
// Rotating priority pick among the six sources
module dtvi_prio #(
    parameter NSRC = 6
) (
    input wire [NSRC-1:0] req_i,
    input wire [2:0] top_i,
    output reg valid_o,
    output reg [2:0] src_o
);
    integer i;
    integer idx;
    integer base;
    // Scan from the top source, wrapping around
    always @*
    begin
        valid_o = 1'b0;
        src_o = 3'h0;
        idx = 0;
        base = (top_i < NSRC) ? top_i : 0;
        for (i = 0; i < NSRC; i = i + 1)
        begin
            idx = (base + i) % NSRC;
            if (!valid_o && req_i[idx])
            begin
                valid_o = 1'b1;
                src_o = idx[2:0];
            end
        end
    end
endmodule // dtvi_prio
`default_nettype wire

// [core/dtvi_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "dtvi_map.vh"
module dtvi_top #(
    parameter NSRC = 6,
    parameter PRE_W = 6,
    parameter CNT_W = 8
) (
    input wire clk_sys_i,
    input wire nrst_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    output wire [7:0] reg_rdata_o,
    input wire input_line_one_i,
    input wire input_line_two_i,
    input wire input_line_three_i,
    input wire analog_mode_i,
    input wire [2:0] analog_cmp_i,
    output wire irq_req_o,
    output wire [2:0] irq_src_o,
    output wire [15:0] irq_vec_addr_o,
    input wire irq_ack_i
);
    // Falling edge between last and current sample
    function fall;
        input prev;
        input cur;
        begin
            fall = prev & ~cur;
        end
    endfunction

    // Rising edge between last and current sample
    function rise;
        input prev;
        input cur;
        begin
            rise = ~prev & cur;
        end
    endfunction

    // Write strobe for one address
    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input wr;
        begin
            wr_hit = wr & (addr == target);
        end
    endfunction

    reg [7:0] mode_ff; // Timer mode, load bits not kept
    reg [7:0] scl0_ff; // First prescaler setting
    reg [7:0] scl1_ff; // Second prescaler setting
    reg [7:0] init0_ff; // First counter initial value
    reg [7:0] init1_ff; // Second counter initial value
    reg [7:0] prio_ff; // Priority select
    reg [7:0] mask_ff; // Enable mask with global bit
    reg [NSRC-1:0] pend_ff; // Pending requests
    reg [NSRC-1:0] nxt_pend;
    reg [7:0] rdata_ff; // Read data
    reg [7:0] nxt_rdata;
    reg [2:0] lines_ff; // Previous line samples
    reg prim_ff; // Edge detection armed after reset
    reg [1:0] div4_ff; // Internal clock divider
    reg armed_ff; // Second timer triggered
    reg req_ff; // Interrupt request to core
    reg [2:0] src_ff; // Granted-to-be source
    reg [15:0] vec_ff; // Vector location of that source
    reg tick1; // Second timer step enable
    reg run1; // Second timer running

    wire [2:0] lines; // Current line values
    wire int_tick; // Internal clock divided by four
    wire ext_lvl; // External timer input level
    wire ext_fall; // External timer input edge
    wire [1:0] ext_mode; // External input use
    wire src_ext; // Second timer on external clock
    wire trig_mode; // Either trigger mode
    wire trig_ok; // Trigger accepted
    wire ld0; // First timer restart
    wire ld1; // Second timer restart
    wire en0; // First timer run
    wire en1; // Second timer run
    wire [CNT_W-1:0] cnt0; // First counter now
    wire [CNT_W-1:0] cnt1; // Second counter now
    wire eoc0; // First timer end pulse
    wire eoc1; // Second timer end pulse
    wire [NSRC-1:0] set_vec; // Hardware set events
    wire [NSRC-1:0] enabled; // Pending and unmasked
    wire pick_valid; // Encoder found a request
    wire [2:0] pick_src; // Encoder choice
    wire grant; // Core takes the request

    // Analog mode swaps in comparator outputs
    assign lines = analog_mode_i ? analog_cmp_i :
        {input_line_three_i, input_line_two_i, input_line_one_i};
    assign ext_lvl = lines[0];
    assign ext_fall = prim_ff & fall(lines_ff[0], lines[0]);
    assign ext_mode = mode_ff[`DTVI_MODE_EXT];
    assign src_ext = ~scl1_ff[`DTVI_PRE_SRC];
    assign trig_mode = (ext_mode == `DTVI_EXT_TRIG) |
        (ext_mode == `DTVI_EXT_RTRIG);
    assign int_tick = (div4_ff == `DTVI_DIV4_LAST);

    // Load bits act as one-shot restart strobes
    assign ld0 = wr_hit(reg_addr_i, `DTVI_A_MODE, reg_wr_i) &
        reg_wdata_i[`DTVI_MODE_LD0];
    assign trig_ok = ext_fall & en1 & ((ext_mode == `DTVI_EXT_RTRIG) |
        ((ext_mode == `DTVI_EXT_TRIG) & ~armed_ff));
    assign ld1 = (wr_hit(reg_addr_i, `DTVI_A_MODE, reg_wr_i) &
        reg_wdata_i[`DTVI_MODE_LD1]) | trig_ok;
    assign en0 = mode_ff[`DTVI_MODE_EN0];
    assign en1 = mode_ff[`DTVI_MODE_EN1];

    // Second timer clock: divided clock, pin edge or gated
    always @*
    begin
        tick1 = int_tick;
        run1 = en1;
        case (ext_mode)
            `DTVI_EXT_CLK:
                tick1 = src_ext ? ext_fall : int_tick;
            `DTVI_EXT_GATE:
                tick1 = int_tick & ext_lvl;
            `DTVI_EXT_TRIG,
            `DTVI_EXT_RTRIG:
                run1 = en1 & armed_ff;
            default:
                tick1 = int_tick;
        endcase
    end

    // First timer: internal clock only
    dtvi_timer #(
        .PRE_W(PRE_W),
        .CNT_W(CNT_W)
    ) u_first (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .tick_i(int_tick),
        .run_i(en0),
        .load_i(ld0),
        .cont_i(scl0_ff[`DTVI_PRE_CONT]),
        .pre_init_i(scl0_ff[`DTVI_PRE_DIV]),
        .cnt_init_i(init0_ff),
        .count_o(cnt0),
        .eoc_o(eoc0),
        .done_o()
    );

    // Second timer: selectable source
    dtvi_timer #(
        .PRE_W(PRE_W),
        .CNT_W(CNT_W)
    ) u_second (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .tick_i(tick1),
        .run_i(run1),
        .load_i(ld1),
        .cont_i(scl1_ff[`DTVI_PRE_CONT]),
        .pre_init_i(scl1_ff[`DTVI_PRE_DIV]),
        .cnt_init_i(init1_ff),
        .count_o(cnt1),
        .eoc_o(eoc1),
        .done_o()
    );

    // Event sources, in source-number order
    assign set_vec[`DTVI_SRC_L2F] = prim_ff & fall(lines_ff[1], lines[1]);
    assign set_vec[`DTVI_SRC_L3F] = prim_ff & fall(lines_ff[2], lines[2]);
    assign set_vec[`DTVI_SRC_L1F] = prim_ff & fall(lines_ff[0], lines[0]);
    assign set_vec[`DTVI_SRC_L2R] = prim_ff & rise(lines_ff[1], lines[1]);
    assign set_vec[`DTVI_SRC_CNT0] = eoc0;
    assign set_vec[`DTVI_SRC_CNT1] = eoc1;

    // Mask only gates requests, never pending state
    assign enabled = pend_ff & mask_ff[`DTVI_MASK_SRC] &
        {NSRC{mask_ff[`DTVI_MASK_GEN]}};

    dtvi_prio #(
        .NSRC(NSRC)
    ) u_prio (
        .req_i(enabled),
        .top_i(prio_ff[`DTVI_PRIO_TOP]),
        .valid_o(pick_valid),
        .src_o(pick_src)
    );

    assign grant = irq_ack_i & req_ff;

    // Pending: write, then grant clear, then set wins
    always @*
    begin
        nxt_pend = pend_ff;
        if (wr_hit(reg_addr_i, `DTVI_A_IRQ, reg_wr_i))
            nxt_pend = reg_wdata_i[`DTVI_IRQ_BITS];
        if (grant)
            nxt_pend[src_ff] = 1'b0;
        nxt_pend = nxt_pend | set_vec;
    end

    // Read mux; prescalers are write-only
    always @*
    begin
        case (reg_addr_i)
            `DTVI_A_MODE:
                nxt_rdata = mode_ff;
            `DTVI_A_CNT1:
                nxt_rdata = cnt1;
            `DTVI_A_CNT0:
                nxt_rdata = cnt0;
            `DTVI_A_PRIO:
                nxt_rdata = prio_ff;
            `DTVI_A_IRQ:
                nxt_rdata = {2'b00, pend_ff};
            `DTVI_A_MASK:
                nxt_rdata = mask_ff;
            default:
                nxt_rdata = `DTVI_ZERO8;
        endcase
    end

    // Register file writes
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_ff <= `DTVI_RST_MODE;
            scl0_ff <= `DTVI_RST_PRE;
            scl1_ff <= `DTVI_RST_PRE;
            init0_ff <= `DTVI_RST_CNT;
            init1_ff <= `DTVI_RST_CNT;
            prio_ff <= `DTVI_RST_PRIO;
            mask_ff <= `DTVI_RST_MASK;
            pend_ff <= `DTVI_RST_IRQ;
        end
        else
        begin
            pend_ff <= nxt_pend;
            if (wr_hit(reg_addr_i, `DTVI_A_MODE, reg_wr_i))
                mode_ff <= reg_wdata_i & `DTVI_MODE_KEEP;
            if (wr_hit(reg_addr_i, `DTVI_A_SCL0, reg_wr_i))
                scl0_ff <= reg_wdata_i;
            if (wr_hit(reg_addr_i, `DTVI_A_SCL1, reg_wr_i))
                scl1_ff <= reg_wdata_i;
            // Counter writes only set the initial value
            if (wr_hit(reg_addr_i, `DTVI_A_CNT0, reg_wr_i))
                init0_ff <= reg_wdata_i;
            if (wr_hit(reg_addr_i, `DTVI_A_CNT1, reg_wr_i))
                init1_ff <= reg_wdata_i;
            if (wr_hit(reg_addr_i, `DTVI_A_PRIO, reg_wr_i))
                prio_ff <= reg_wdata_i;
            // Grant beats a same-cycle mask write
            if (grant)
                mask_ff <= mask_ff & `DTVI_MASK_NOGEN;
            else if (wr_hit(reg_addr_i, `DTVI_A_MASK, reg_wr_i))
                mask_ff <= reg_wdata_i;
        end
    end

    // Line history, divider and trigger state
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            lines_ff <= `DTVI_RST_LINES;
            prim_ff <= 1'b0;
            div4_ff <= `DTVI_RST_DIV4;
            armed_ff <= 1'b0;
        end
        else
        begin
            lines_ff <= lines;
            // First cycle's history is junk; skip it
            prim_ff <= 1'b1;
            div4_ff <= div4_ff + `DTVI_DIV4_STEP;
            if (!en1 || !trig_mode)
                armed_ff <= 1'b0;
            else if (trig_ok)
                armed_ff <= 1'b1;
            else if (eoc1 && !scl1_ff[`DTVI_PRE_CONT])
                armed_ff <= 1'b0;
        end
    end

    // Request, source and vector toward the core
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            req_ff <= 1'b0;
            src_ff <= `DTVI_RST_SRC;
            vec_ff <= `DTVI_RST_VEC;
            rdata_ff <= `DTVI_ZERO8;
        end
        else
        begin
            // Dropped at grant so no double take
            req_ff <= pick_valid & ~grant;
            if (pick_valid && !grant)
            begin
                src_ff <= pick_src;
                vec_ff <= {12'h000, pick_src, 1'b0};
            end
            if (reg_rd_i)
                rdata_ff <= nxt_rdata;
        end
    end

    // Core fetches the two vector bytes as one address
    assign irq_vec_addr_o = vec_ff;
    assign irq_src_o = src_ff;
    assign irq_req_o = req_ff;
    assign reg_rdata_o = rdata_ff;
endmodule // dtvi_top
`default_nettype wire

// [dv/dtvi_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the core side of the timer block
module dtvi_top_checker (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_req_o,
    input wire logic [2:0] irq_src_o,
    input wire logic [15:0] irq_vec_addr_o,
    input wire logic irq_ack_i
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    logic gen_ff; // Shadow of the global enable bit
    // Shadow follows mask writes; a grant drops it
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
            gen_ff <= 1'b0;
        else if (reg_wr_i && reg_addr_i == 8'hfb)
            gen_ff <= reg_wdata_i[7];
        else if (irq_req_o && irq_ack_i)
            gen_ff <= 1'b0;
    end
    // Grant with no competing register write
    sequence s_grant;
        irq_req_o && irq_ack_i && !reg_wr_i;
    endsequence
    // Read request to one address
    sequence s_rd(a);
        reg_rd_i && reg_addr_i == a;
    endsequence
    a_grant_drops: assert property (s_grant |=> !irq_req_o [*2])
        else $error("request stayed up after grant");
    a_vec_twice: assert property (irq_req_o |-> irq_vec_addr_o == {12'h000, irq_src_o, 1'b0})
        else $error("vector location not twice the source");
    a_src_range: assert property (irq_req_o |-> irq_src_o <= 3'h5)
        else $error("request from a source beyond five");
    a_mask_gates: assert property ((!gen_ff) [*3] |-> !irq_req_o)
        else $error("request while globally disabled");
    a_pre_unread: assert property ((s_rd(8'hf3) or s_rd(8'hf5)) |=> reg_rdata_o == 8'h00)
        else $error("prescaler setting readable");
    a_irq_top: assert property (s_rd(8'hfa) |=> reg_rdata_o[7:6] == 2'h0)
        else $error("pending flags upper bits not zero");
    a_tmr_pulse: assert property (s_rd(8'hf1) |=> !reg_rdata_o[0] && !reg_rdata_o[2])
        else $error("load bits read back nonzero");
    a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
endmodule // dtvi_top_checker
bind dtvi_top dtvi_top_checker i_dtvi_top_checker (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_req_o(irq_req_o),
    .irq_src_o(irq_src_o),
    .irq_vec_addr_o(irq_vec_addr_o),
    .irq_ack_i(irq_ack_i)
);
`default_nettype wire

// [dv/dtvi_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Core model: register cycles and interrupt grants
module dtvi_core_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic ack_en_i,
    input wire logic [1:0] ack_dly_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic irq_req_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    output logic irq_ack_o
);
    logic [1:0] wait_ff; // Cycles spent before granting
    // Bus idle at time zero
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    // One write; the block takes it at the next rising edge
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_wr_o = 1'b0;
        reg_wdata_o = ~d; // Released data shows junk, not the old value
    endtask
    // One read; registered data is settled just after the taking edge
    task rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask
    // Grant after a chosen delay, one cycle wide; core saves state itself
    always @(posedge clk_sys_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            irq_ack_o <= 1'b0;
            wait_ff <= 2'h0;
        end
        else if (irq_ack_o)
            irq_ack_o <= 1'b0;
        else if (irq_req_i && ack_en_i && wait_ff == ack_dly_i)
        begin
            irq_ack_o <= 1'b1;
            wait_ff <= 2'h0;
        end
        else if (irq_req_i && ack_en_i)
            wait_ff <= wait_ff + 2'h1;
        else
            wait_ff <= 2'h0;
    end
endmodule // dtvi_core_model
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the timer and interrupt block
module tb_top;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [2:0] lines = 3'h7; // Lines one..three, idle high
    logic analog_mode = 1'b0;
    logic [2:0] analog_cmp = 3'h7;
    logic ack_en = 1'b0;
    logic [1:0] ack_dly = 2'h0;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_wr, reg_rd, irq_req, irq_ack;
    wire [2:0] irq_src;
    wire [15:0] irq_vec;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t, e, p, n, k, top, oth;
    logic [7:0] d;
    logic [7:0] regs [9] = '{8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf9, 8'hfa, 8'hfb, 8'hf0};
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc++;
    dtvi_top i_dtvi_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr),
        .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .input_line_one_i(lines[0]), .input_line_two_i(lines[1]),
        .input_line_three_i(lines[2]), .analog_mode_i(analog_mode), .analog_cmp_i(analog_cmp),
        .irq_req_o(irq_req), .irq_src_o(irq_src), .irq_vec_addr_o(irq_vec), .irq_ack_i(irq_ack));
    dtvi_core_model i_dtvi_core_model (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .ack_en_i(ack_en), .ack_dly_i(ack_dly), .reg_rdata_i(reg_rdata), .irq_req_i(irq_req),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd),
        .irq_ack_o(irq_ack));
    // Closing verdict
    task print_verdict();
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Plain value compare; rdc applies the mask
    task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        cmp_count++;
        if (g !== x)
        begin
            $display("BAD %s expected %h seen %h", nm, x, g);
            fail_count++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        i_dtvi_core_model.wr_reg(a, v);
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m);
        i_dtvi_core_model.rd_reg(a, d);
        chk($sformatf("reg_%h", a), {8'h00, x & m}, {8'h00, d & m});
    endtask
    // Cycles from load to end: tick every four clocks, 0 means full span
    function int exp_ticks(int pv, int nv);
        return 4 * (pv == 0 ? 64 : pv) * (nv == 0 ? 256 : nv);
    endfunction
    // Line bit that raises a falling-edge source
    function logic [2:0] line_of(int s);
        return s == 0 ? 3'h2 : (s == 1 ? 3'h4 : 3'h1);
    endfunction
    // Drive lines, then wait four cycles for the edge to take effect
    task set_lines(input logic [2:0] v);
        @(posedge clk_sys_i);
        #1;
        lines = v;
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask
    // Wait, bounded, for the request level
    task wait_lvl(input logic v);
        for (int i = 0; i < 40 && irq_req !== v; i++)
        begin
            @(posedge clk_sys_i);
            #1;
        end
        chk("irq_req", {15'h0, v}, {15'h0, irq_req});
    endtask
    // Poll a pending bit; t is -1 if it never came
    task wait_pend(input int b, input int lim);
        int s;
        s = cyc;
        t = -1;
        while (cyc - s < lim && t < 0)
        begin
            i_dtvi_core_model.rd_reg(8'hfa, d);
            if (d[b] === 1'b1)
                t = cyc - s;
        end
    endtask
    // Hang guard, well beyond the expected run
    initial
    begin
        #900000;
        fail_count++;
        print_verdict();
    end
    // Main sequence
    initial
    begin
        void'($urandom(22603));
        repeat (6) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        foreach (regs[i]) rdc(regs[i], 8'h00, 8'hff);
        d = 8'($urandom);
        wr(8'hfb, d & 8'h3f);
        rdc(8'hfb, d & 8'h3f, 8'hbf);
        wr(8'hf1, d & 8'hf0);
        rdc(8'hf1, d & 8'hf0, 8'hff);
        for (k = 0; k < 3; k++)
        begin
            p = k == 0 ? 0 : 1 + $urandom % 4;
            n = k == 0 ? 1 : 1 + $urandom % 6;
            e = exp_ticks(p, n);
            wr(8'hf1, 8'h00);
            wr(8'hf5, {p[5:0], 2'b00});
            wr(8'hf4, n[7:0]);
            wr(8'hfa, 8'h00);
            wr(8'hf1, 8'h03);
            wait_pend(4, e + 40);
            chk("t0_time", 16'h1, {15'h0, t >= e - 4 && t <= e + 10});
            wr(8'hfa, 8'h00);
            repeat (e) @(posedge clk_sys_i);
            rdc(8'hfa, 8'h00, 8'h10);
            rdc(8'hf4, 8'h00, 8'hff);
        end
        p = 1 + $urandom % 3;
        n = 2 + $urandom % 3;
        e = exp_ticks(p, n);
        wr(8'hf3, {p[5:0], 2'b11});
        wr(8'hf2, n[7:0]);
        wr(8'hfa, 8'h00);
        wr(8'hf1, 8'h0c);
        wait_pend(5, e + 40);
        wr(8'hfa, 8'h00);
        wait_pend(5, e + 40);
        chk("t1_reload", 16'h1, {15'h0, t >= e - 12 && t <= e + 10});
        wr(8'hf1, 8'h00);
        i_dtvi_core_model.rd_reg(8'hf2, d);
        repeat (40) @(posedge clk_sys_i);
        rdc(8'hf2, d, 8'hff);
        wr(8'hfa, 8'h00);
        wr(8'hf1, 8'h08);
        wait_pend(5, e + 40);
        chk("t1_resume", 16'h1, {15'h0, t >= 0 && t <= e + 10});
        wr(8'hf1, 8'h00);
        wr(8'hf3, 8'h04);
        wr(8'hf2, 8'h02);
        wr(8'hf1, 8'h0c);
        wr(8'hfa, 8'h00);
        set_lines(3'h6);
        set_lines(3'h7);
        rdc(8'hfa, 8'h00, 8'h20);
        set_lines(3'h6);
        set_lines(3'h7);
        rdc(8'hfa, 8'h20, 8'h20);
        for (k = 1; k < 4; k++)
        begin
            wr(8'hf1, 8'h00);
            wr(8'hf3, 8'h06);
            wr(8'hf2, 8'h03);
            wr(8'hfa, 8'h00);
            wr(8'hf1, {2'b00, k[1:0], 4'hc});
            set_lines(3'h6);
            set_lines(3'h7);
            wait_pend(5, 80);
            chk("mode_end", 16'h1, {15'h0, t >= 0});
        end
        wr(8'hf1, 8'h00);
        ack_en = 1'b1;
        for (k = 0; k < 6; k++)
        begin
            top = $urandom % 3;
            oth = (top + 1 + $urandom % 2) % 3;
            // A zero delay grants before set_lines hands back
            ack_dly = 2'(1 + $urandom % 3);
            wr(8'hf9, top[7:0]);
            wr(8'hfa, 8'h00);
            wr(8'hfb, 8'h87);
            set_lines(~(line_of(top) | line_of(oth)));
            wait_lvl(1'b1);
            chk("src_top", top[15:0], {13'h0, irq_src});
            chk("vec_top", {top[14:0], 1'b0}, irq_vec);
            wait_lvl(1'b0);
            rdc(8'hfa, 8'h01 << oth, 8'h07);
            wr(8'hfb, 8'h87);
            wait_lvl(1'b1);
            chk("src_next", oth[15:0], {13'h0, irq_src});
            wait_lvl(1'b0);
            set_lines(3'h7);
        end
        wr(8'hfa, 8'h00);
        wr(8'hfb, 8'h88);
        set_lines(3'h5);
        set_lines(3'h7);
        wait_lvl(1'b1);
        chk("src_rise", 16'h3, {13'h0, irq_src});
        chk("vec_rise", 16'h6, irq_vec);
        wait_lvl(1'b0);
        ack_en = 1'b0;
        wr(8'hfb, 8'h02);
        wr(8'hfa, 8'h00);
        set_lines(3'h3);
        rdc(8'hfa, 8'h02, 8'h3f);
        chk("irq_masked", 16'h0, {15'h0, irq_req});
        wr(8'hfa, 8'h00);
        rdc(8'hfa, 8'h00, 8'h3f);
        set_lines(3'h7);
        analog_mode = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        wr(8'hfa, 8'h00);
        analog_cmp = 3'h6;
        repeat (5) @(posedge clk_sys_i);
        rdc(8'hfa, 8'h04, 8'h04);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
